//--- core/rrj_jump_unit.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RQ1: region call links pc plus eight
// RQ2: link bit 0 holds old isa select
// RQ3: region target from slot upper bits
// RQ4: last-word jump lands in next region
// RQ5: region call inverts isa select
// RQ6: delay slot executes before target
// RQ7: no compressed isa: reserved instruction
// RQ8: software keeps region targets word aligned
// RQ9: register jump loads select, clears bit 0; without compressed isa the code keeps select and the whole target
// RQ10: no compressed isa: low two bits fault
// RQ11: compressed: bit0 zero, bit1 one faults
// RQ12: instruction bit 10 selects barrier
// RQ13: hint zero means default register jump
// RQ14: barrier clears execution and instruction hazards
// RQ15: barrier legal in every mode
// RQ16: delay-slot hazards need not clear
// RQ17: no control transfer in delay slot
// RQ18: non-micro software gives aligned target
// RQ19: software clears hazards after stream change
// RQ20: register 31 source for returns
// RQ21: barrier waits for earlier system writes
// RQ22: pc and select update after slot
module rrj_jump_unit
  import rrj_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          clk_en,
  // configuration
  input  wire logic          compressed_isa_present,
  input  wire logic          cop0_enabled,
  // issue side
  input  wire rrj_pkg::rrj_issue_s issue,
  input  wire logic [31:0]   source_reg_value,
  input  wire logic          slot_done,
  input  wire logic          sys_writes_pending,
  // register file write
  output rrj_pkg::rrj_link_s link_wr,
  // redirect
  output logic               redirect_valid,
  output logic [31:0]        redirect_pc,
  output logic               instruction_set_select,
  // hazards and exceptions
  output logic               hazard_clear,
  output logic               fetch_hold,
  output rrj_pkg::rrj_exc_s  exc,
  output logic               jump_busy
);
  import rrj_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic is_region_x;
  logic is_reg_jump;
  logic is_barrier;
  logic [31:0] slot_pc;
  logic [31:0] region_tgt;
  logic [31:0] reg_tgt;
  logic        reg_isa;

  always_comb
  begin
    is_region_x = issue.valid && (issue.word[31:26] == OP_REGION_X);
    is_reg_jump = issue.valid && (issue.word[31:26] == OP_SPECIAL)
                  && (issue.word[5:0] == FN_REG_JUMP);
    // bit 10 picks barrier; other hint bits give default handling
    is_barrier  = is_reg_jump && issue.word[HINT_BAR_BIT]; // RQ12 RQ13 RQ15
    slot_pc     = issue.pc + SLOT_OFFSET;
    // upper bits from the slot, so a last-word jump enters next region
    region_tgt  = {slot_pc[31:REGION_BITS],
                   issue.word[25:0], 2'b00}; // RQ3 RQ4
    if (compressed_isa_present)
    begin
      reg_tgt = {source_reg_value[31:1], 1'b0}; // RQ9
      reg_isa = source_reg_value[0]; // RQ9
    end
    else
    begin
      reg_tgt = source_reg_value; // RQ9
      reg_isa = instruction_set_select;
    end
  end

  // ----------------------------------------------------------------
  // jump sequencer
  // ----------------------------------------------------------------
  rrj_state_e  state_r, state_nxt;
  logic [31:0] tgt_r, tgt_nxt;
  logic        new_isa_r, new_isa_nxt;
  logic        bar_r, bar_nxt;
  logic        isa_r, isa_nxt;
  logic        redir_r, redir_nxt;
  logic [31:0] rpc_r, rpc_nxt;
  logic        hclr_r, hclr_nxt;
  logic        hold_r, hold_nxt;
  logic        busy_r, busy_nxt;
  rrj_link_s   link_r, link_nxt;
  rrj_exc_s    exc_r, exc_nxt;
  logic        tgt_fault;
  logic [31:0] chk_tgt;

  // fault looks at source bit 0 (the new select), not the cleared pc bit
  assign chk_tgt = compressed_isa_present ? {tgt_r[31:1], new_isa_r} : tgt_r; // RQ11

  rrj_target_check u_check (
    .target                 (chk_tgt),
    .compressed_isa_present (compressed_isa_present),
    .fetch_fault            (tgt_fault)
  );

  always_comb
  begin
    state_nxt   = state_r;
    tgt_nxt     = tgt_r;
    new_isa_nxt = new_isa_r;
    bar_nxt     = bar_r;
    isa_nxt     = isa_r;
    redir_nxt   = 1'b0;
    rpc_nxt     = rpc_r;
    hclr_nxt    = 1'b0;
    hold_nxt    = hold_r;
    link_nxt    = '0;
    exc_nxt     = '0;
    case (state_r)
      RRJ_IDLE:
      begin
        if (is_region_x && !compressed_isa_present)
          exc_nxt.reserved_instr = 1'b1; // RQ7
        else if (is_region_x)
        begin
          link_nxt.valid = 1'b1;
          link_nxt.index = LINK_REG; // RQ1
          link_nxt.data  = {issue.pc[31:1] + LINK_OFFSET[31:1], isa_r}; // RQ1 RQ2
          tgt_nxt        = region_tgt;
          new_isa_nxt    = ~isa_r; // RQ5
          bar_nxt        = 1'b0;
          state_nxt      = RRJ_SLOT; // RQ6
        end
        else if (is_reg_jump)
        begin
          tgt_nxt     = reg_tgt;
          new_isa_nxt = reg_isa;
          bar_nxt     = is_barrier;
          // barrier holds fetch of the target while earlier writes drain
          hold_nxt    = is_barrier; // RQ21
          state_nxt   = RRJ_SLOT; // RQ6
        end
      end
      RRJ_SLOT:
      begin
        // slot hazards are not waited on; only writes before the jump count
        if (slot_done)
          state_nxt = bar_r ? RRJ_DRAIN : RRJ_IDLE; // RQ22 RQ16
        if (slot_done && !bar_r)
        begin
          redir_nxt = 1'b1; // RQ22
          rpc_nxt   = tgt_r;
          isa_nxt   = new_isa_r; // RQ22
          exc_nxt.addr_error = tgt_fault; // RQ10 RQ11
        end
      end
      RRJ_DRAIN:
      begin
        if (!sys_writes_pending)
        begin
          redir_nxt = 1'b1; // RQ21
          rpc_nxt   = tgt_r;
          isa_nxt   = new_isa_r; // RQ22
          hclr_nxt  = 1'b1; // RQ14
          hold_nxt  = 1'b0;
          exc_nxt.addr_error = tgt_fault; // RQ10 RQ11
          state_nxt = RRJ_IDLE;
        end
      end
      default:
        state_nxt = RRJ_IDLE;
    endcase
    busy_nxt = (state_nxt != RRJ_IDLE);
  end

  // cop0_enabled is not consulted: the barrier never traps on mode
  logic unused_cop0;
  assign unused_cop0 = cop0_enabled; // RQ15

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r   <= RRJ_IDLE;
      tgt_r     <= RESET_PC;
      new_isa_r <= RESET_ISA;
      bar_r     <= 1'b0;
      isa_r     <= RESET_ISA;
      redir_r   <= 1'b0;
      rpc_r     <= RESET_PC;
      hclr_r    <= 1'b0;
      hold_r    <= 1'b0;
      busy_r    <= 1'b0;
      link_r    <= '0;
      exc_r     <= '0;
    end
    else if (clk_en)
    begin
      state_r   <= state_nxt;
      tgt_r     <= tgt_nxt;
      new_isa_r <= new_isa_nxt;
      bar_r     <= bar_nxt;
      isa_r     <= isa_nxt;
      redir_r   <= redir_nxt;
      rpc_r     <= rpc_nxt;
      hclr_r    <= hclr_nxt;
      hold_r    <= hold_nxt;
      busy_r    <= busy_nxt;
      link_r    <= link_nxt;
      exc_r     <= exc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link_wr                = link_r;
  assign redirect_valid         = redir_r;
  assign redirect_pc            = rpc_r;
  assign instruction_set_select = isa_r;
  assign hazard_clear           = hclr_r;
  assign fetch_hold             = hold_r;
  assign exc                    = exc_r;
  assign jump_busy              = busy_r;

endmodule // rrj_jump_unit

//--- core/rrj_pkg.sv
package rrj_pkg;

  // ----------------------------------------------------------------
  // widths and encodings
  // ----------------------------------------------------------------
  localparam int unsigned XLEN        = 32;
  localparam logic [5:0]  OP_SPECIAL  = 6'h00;
  localparam logic [5:0]  OP_REGION_X = 6'h1d;
  localparam logic [5:0]  FN_REG_JUMP = 6'h08;
  localparam logic [4:0]  LINK_REG    = 5'h1f;
  localparam int unsigned HINT_BAR_BIT = 10;
  localparam int unsigned REGION_BITS  = 28;
  localparam int unsigned IDX_SHIFT    = 2;
  localparam logic [31:0] LINK_OFFSET  = 32'h00000008;
  localparam logic [31:0] SLOT_OFFSET  = 32'h00000004;
  localparam logic [31:0] RESET_PC     = 32'h00000000;
  localparam logic        RESET_ISA    = 1'b0;
  localparam logic [4:0]  HINT_DEFAULT = 5'h00;
  localparam logic [3:0]  DRAIN_MAX    = 4'hf;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RRJ_IDLE  = 2'b00,
    RRJ_SLOT  = 2'b01,
    RRJ_DRAIN = 2'b10
  } rrj_state_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [31:0] pc;
  } rrj_issue_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  index;
    logic [31:0] data;
  } rrj_link_s;

  typedef struct packed {
    logic        reserved_instr;
    logic        addr_error;
  } rrj_exc_s;

endpackage

//--- core/rrj_target_check.sv
`timescale 1ns/1ps
module rrj_target_check
  import rrj_pkg::*;
(
  // target and mode
  input  wire logic [31:0] target,
  input  wire logic        compressed_isa_present,
  // verdict
  output logic             fetch_fault
);

  always_comb
  begin
    if (compressed_isa_present)
      fetch_fault = (target[0] == 1'b0) && (target[1] == 1'b1); // RQ11
    else
      fetch_fault = |target[1:0]; // RQ10
  end

endmodule // rrj_target_check

//--- tb/rrj_prog_model.sv
`timescale 1ns/1ps
module rrj_prog_model
(
  // clock and jump status
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       jump_busy,
  input  wire logic       fetch_hold,
  // pacing
  input  wire logic [1:0] lat,
  input  wire logic [1:0] npend,
  // program side
  output logic            slot_done,
  output logic            sys_writes_pending
);
  // ------------------------------------------------
  // delay slot and system writes
  // ------------------------------------------------
  logic [3:0] wt_r, hd_r;
  logic       sent_r;
  // writes drain only while fetch is held, so the wait is seen only when lat is 0 and npend is 3
  assign sys_writes_pending = fetch_hold && hd_r < {2'h0, npend};
  always @(posedge mclk or negedge reset_n)
    if (!reset_n)
      {slot_done, sent_r, wt_r, hd_r} <= '0;
    else
    begin
      hd_r <= fetch_hold ? hd_r + 4'h1 : 4'h0;
      slot_done <= jump_busy && !sent_r && wt_r == {2'h0, lat};
      sent_r <= jump_busy && (sent_r || wt_r == {2'h0, lat});
      wt_r <= jump_busy ? wt_r + 4'h1 : 4'h0;
    end
endmodule // rrj_prog_model

//--- tb/rrj_properties.sv
`timescale 1ns/1ps
module rrj_properties
  import rrj_pkg::*;
(
  // control
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic compressed_isa_present,
  input wire rrj_pkg::rrj_issue_s issue,
  input wire logic slot_done,
  input wire logic sys_writes_pending,
  // results
  input wire rrj_pkg::rrj_link_s link_wr,
  input wire logic redirect_valid,
  input wire logic instruction_set_select,
  input wire logic hazard_clear,
  input wire logic fetch_hold,
  input wire rrj_pkg::rrj_exc_s exc,
  input wire logic jump_busy
);
  // ------------------------------------------------
  // jump checks
  // ------------------------------------------------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  wire tk = clk_en && !jump_busy && issue.valid;
  wire rj = tk && issue.word[31:26] == OP_SPECIAL && issue.word[5:0] == FN_REG_JUMP;
  sequence s_call;
    tk && issue.word[31:26] == OP_REGION_X;
  endsequence
  sequence s_link;
    link_wr.valid && link_wr.index == LINK_REG;
  endsequence
  property p_link;
    s_call ##0 compressed_isa_present |=> s_link ##0
      link_wr.data == {$past(issue.pc[31:1]) + 31'h4, $past(instruction_set_select)};
  endproperty
  a_link: assert property (p_link) else $error("bad link");
  property p_rsv;
    s_call ##0 !compressed_isa_present |=> exc.reserved_instr;
  endproperty
  a_rsv: assert property (p_rsv) else $error("no reserved");
  property p_bar;
    rj && issue.word[HINT_BAR_BIT] |=> fetch_hold && jump_busy;
  endproperty
  a_bar: assert property (p_bar) else $error("no hold");
  property p_slot;
    clk_en && slot_done && jump_busy && !fetch_hold |=> redirect_valid;
  endproperty
  a_slot: assert property (p_slot) else $error("late redirect");
  property p_early;
    redirect_valid && !hazard_clear |-> $past(slot_done);
  endproperty
  a_early: assert property (p_early) else $error("early redirect");
  property p_wait;
    fetch_hold && sys_writes_pending |=> !redirect_valid;
  endproperty
  a_wait: assert property (p_wait) else $error("no drain");
  property p_clr;
    redirect_valid |-> hazard_clear == $past(fetch_hold) && !fetch_hold;
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_isa;
    !redirect_valid |-> $stable(instruction_set_select);
  endproperty
  a_isa: assert property (p_isa) else $error("isa moved");
endmodule // rrj_properties

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import rrj_pkg::*;
  // ------------------------------------------------
  // bench
  // ------------------------------------------------
  logic mclk = 1'b0, reset_n = 1'b0, cmp = 1'b1, cop0 = 1'b0, isa_m = 1'b0, ce = 1'b1;
  logic sd, pend, rv, isa, hz, fh, busy;
  logic [1:0] lat = 2'h0, np = 2'h0;
  logic [15:0] lf = 16'hf158;
  logic [31:0] src = 32'h0, rpc;
  rrj_issue_s issue = '0;
  rrj_link_s lw;
  rrj_exc_s exc;
  int num_errors = 0, comparisons = 0;
  always #25 mclk = ~mclk;
  rrj_jump_unit dut_u (.mclk(mclk), .reset_n(reset_n), .clk_en(ce),
    .compressed_isa_present(cmp), .cop0_enabled(cop0), .issue(issue),
    .source_reg_value(src), .slot_done(sd), .sys_writes_pending(pend),
    .link_wr(lw), .redirect_valid(rv), .redirect_pc(rpc), .instruction_set_select(isa),
    .hazard_clear(hz), .fetch_hold(fh), .exc(exc), .jump_busy(busy));
  rrj_prog_model prog_u (.mclk(mclk), .reset_n(reset_n), .jump_busy(busy),
    .fetch_hold(fh), .lat(lat), .npend(np), .slot_done(sd), .sys_writes_pending(pend));
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic jump(input int k, input logic c, input logic [31:0] p, input logic [31:0] s);
    logic [31:0] t, w;
    logic b, f, i_n;
    int n;
    b = (k == 2);
    t = p + SLOT_OFFSET;
    t = {t[31:28], s[25:0], 2'h0};
    i_n = ~isa_m;
    f = 1'b0;
    w = {OP_REGION_X, s[25:0]};
    if (k != 0)
    begin
      w = {OP_SPECIAL, LINK_REG, 10'h0, b, 4'h0, FN_REG_JUMP};
      t = c ? {s[31:1], 1'b0} : s;
      i_n = c ? s[0] : isa_m;
      f = c ? (!s[0] && s[1]) : (s[1:0] != 2'h0);
    end
    @(posedge mclk);
    cmp <= c;
    cop0 <= s[7];
    src <= s;
    issue <= {1'b1, w, p};
    @(posedge mclk);
    issue <= '0;
    #1;
    if (k == 0) chk(exc.reserved_instr, !c);
    if (k == 0 && !c) return;
    if (k == 0) chk(lw.data, (p + LINK_OFFSET) | {31'h0, isa_m});
    chk({lw.valid, fh}, {k == 0, b});
    for (n = 0; n < 40 && rv !== 1'b1; n++)
    begin
      @(posedge mclk);
      #1;
    end
    if (n == 40)
    begin
      num_errors++;
      end_of_test();
    end
    else
    begin
      chk(rpc, t);
      chk({isa, exc.addr_error, hz}, {i_n, f, b});
      isa_m = i_n;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk({isa, rv, lw.valid, fh}, 4'h0);
    // clock enable low: an issue must be ignored and no state move
    @(posedge mclk);
    ce <= 1'b0;
    issue <= {1'b1, OP_REGION_X, 26'h0000010, 32'h00000040};
    @(posedge mclk);
    issue <= '0;
    ce <= 1'b1;
    #1;
    chk({lw.valid, busy, isa}, 3'h0);
    for (int i = 0; i < 30; i++)
    begin
      lat = 2'(rnd() % 3);
      np = 2'(rnd() % 4);
      // region calls stay word aligned by their encoding
      jump(i % 3, i % 3 == 0 || rnd() % 2 == 0,
        (i == 3) ? 32'h0ffffffc : {rnd(), rnd()} & 32'hfffffffc, {rnd(), rnd()});
    end
    jump(0, 1'b0, 32'h00000100, 32'h00000000);
    repeat (4) @(posedge mclk);
    end_of_test();
  end
endmodule // tb
bind rrj_jump_unit rrj_properties chk_u (.*);
